// File: rtl/lrdimm_buffer_cal_status.sv
// calibration sequencer for a dual-rank load-reduced module: runs the
// per-rank buffer stages, gate calibration and gate check, and reports
// progress on a 128-bit status port and three 9-bit debug words.
// assumes the buffer answers each read or strobe probe with one result.
`include "cal_status_cfg.svh"
module lrdimm_buffer_cal_status
   import cal_status_pkg::*;
(
   // clock, reset, enable
   input  wire logic                      ref_clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      ce_i,
   // sequence control
   input  wire logic                      cal_start_i,
   // result from the data buffer on the host data bus
   input  wire logic                      dq_result_valid_i,
   input  wire logic                      dq_result_i,
   // commands toward buffer and memory
   output logic                           cmd_valid_o,
   output cal_status_pkg::cmd_t           cmd_o,
   output logic                           cmd_rank_o,
   output logic [`TAP_W-1:0]              cmd_delay_o,
   // progress reporting
   output logic [`STATUS_W-1:0]           cal_status_o,
   output logic [`DBG_W-1:0]              cal_progress_word_0_o,
   output logic [`DBG_W-1:0]              cal_progress_word_1_o,
   output logic [`DBG_W-1:0]              cal_progress_word_2_o,
   output logic                           calibration_complete_o,
   output logic                           cal_error_o
);
   import cal_status_pkg::*;

   seq_state_t             state_q, state_d;
   logic [`STAGE_W-1:0]    stage_q, stage_d;
   logic                   wr_pend_q, wr_pend_d;
   logic                   cmd_valid_d;
   cmd_t                   cmd_d;
   logic [`TAP_W-1:0]      delay_d;
   wire  [`STATUS_W-1:0]   status_d;
   logic                   complete_d, error_d;

   // engine connections
   logic                   eng_start, eng_probe, eng_done, eng_fail;
   logic [`TAP_W-1:0]      eng_tap, eng_final;
   search_mode_t           stage_mode;

   // stage decode: rank and position within the rank
   wire                    is_buf   = (stage_q < `BUF_STAGES_END);
   wire                    rank_one = is_buf && (stage_q >= `BUF_PER_RANK);
   wire [`STAGE_W-1:0]     pos      = rank_one ? stage_q - `BUF_PER_RANK
                                               : stage_q;
   wire                    is_gate  = (stage_q == `GATE_STAGE);
   wire                    is_check = (stage_q == `SANITY_STAGE);
   wire                    is_level = is_buf && pos == `POS_WR_LEVEL;
   wire                    is_probe = is_buf && pos == `POS_PROBE;
   wire                    uses_write = is_check || (is_buf &&
                              (pos == `POS_WR_CYCLE ||
                               pos == `POS_WR_CENTER));
   wire                    uses_pattern = uses_write || (is_buf &&
                              (pos == `POS_RD_CYCLE ||
                               pos == `POS_RD_CENTER));
   wire                    last_stage = is_check;
   wire                    in_run   = (state_q == SEQ_RUN);

   // search mode per stage, order fixed per rank
   assign stage_mode = is_check ? MODE_CHECK :
                       is_gate  ? MODE_EDGE01 :
                       is_probe ? MODE_EDGE10 :
                       is_level ? MODE_EDGE01 :
                       (pos == `POS_RD_CYCLE || pos == `POS_WR_CYCLE)
                                ? MODE_CYCLE : MODE_CENTER;

   assign eng_start = (state_q == SEQ_SETUP);

   // per-rank delay search for the current stage
   tap_search u_search (
      .ref_clk_i      (ref_clk_i),
      .rst_n_i        (rst_n_i),
      .ce_i           (ce_i),
      .start_i        (eng_start),
      .mode_i         (stage_mode),
      .result_valid_i (dq_result_valid_i && in_run),
      .result_i       (dq_result_i),
      .probe_o        (eng_probe),
      .tap_o          (eng_tap),
      .done_o         (eng_done),
      .fail_o         (eng_fail),
      .final_o        (eng_final)
   );

   // start and done flags per stage, even then odd bit
   genvar g;
   generate
      for (g = 0; g < `STAGE_COUNT; g = g + 1) begin : g_stage
         wire hit_stage = (stage_q == `STAGE_W'(g));
         assign status_d[2*g] = cal_status_o[2*g]
                              | (eng_start && hit_stage);
         assign status_d[2*g+1] = cal_status_o[2*g+1]
                              | (in_run && eng_done && hit_stage);
      end
   endgenerate
   assign status_d[`STATUS_W-1:`STATUS_USED] = '0;

   // sequencer next state and command choice
   always_comb begin
      state_d     = state_q;
      stage_d     = stage_q;
      wr_pend_d   = 1'b0;
      cmd_valid_d = 1'b0;
      cmd_d       = CMD_NONE;
      delay_d     = eng_tap;
      complete_d  = calibration_complete_o;
      error_d     = cal_error_o;
      unique case (state_q)
         SEQ_IDLE: if (cal_start_i) begin
            stage_d = '0;
            state_d = SEQ_SETUP;
         end
         SEQ_SETUP: begin
            // load the buffer's expected pattern before searching
            if (uses_pattern) begin
               cmd_valid_d = 1'b1;
               cmd_d       = CMD_PRELOAD;
            end
            state_d = SEQ_RUN;
         end
         SEQ_RUN: begin
            if (wr_pend_q) begin
               cmd_valid_d = 1'b1;
               cmd_d       = CMD_READ;
            end else if (eng_probe) begin
               cmd_valid_d = 1'b1;
               if (uses_write) begin
                  cmd_d     = CMD_WRITE;
                  wr_pend_d = 1'b1;
               end else if (is_level) begin
                  cmd_d = CMD_STROBE;
               end else begin
                  cmd_d = CMD_READ;
               end
            end
            if (eng_fail) begin
               error_d = 1'b1;
               state_d = SEQ_FAIL;
            end else if (eng_done) begin
               // program the found setting into the buffer
               if (is_buf) begin
                  cmd_valid_d = 1'b1;
                  cmd_d       = CMD_PROGRAM;
                  delay_d     = eng_final;
               end
               if (last_stage) begin
                  complete_d = 1'b1;
                  state_d    = SEQ_DONE;
               end else begin
                  stage_d = stage_q + 4'h1;
                  state_d = SEQ_SETUP;
               end
            end
         end
         SEQ_DONE,
         SEQ_FAIL: state_d = state_q;
         default:  state_d = SEQ_IDLE;
      endcase
   end

   // sequencer and command registers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_q     <= SEQ_IDLE;
         stage_q     <= '0;
         wr_pend_q   <= 1'b0;
         cmd_valid_o <= 1'b0;
         cmd_o       <= CMD_NONE;
         cmd_rank_o  <= 1'b0;
         cmd_delay_o <= '0;
      end else if (ce_i) begin
         state_q     <= state_d;
         stage_q     <= stage_d;
         wr_pend_q   <= wr_pend_d;
         cmd_valid_o <= cmd_valid_d;
         cmd_o       <= cmd_d;
         cmd_rank_o  <= rank_one;
         cmd_delay_o <= delay_d;
      end
   end

   // status port, debug words and completion flags
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cal_status_o           <= `STATUS_RESET;
         cal_progress_word_0_o  <= `DBG_RESET;
         cal_progress_word_1_o  <= `DBG_RESET;
         cal_progress_word_2_o  <= `DBG_RESET;
         calibration_complete_o <= 1'b0;
         cal_error_o            <= 1'b0;
      end else if (ce_i) begin
         cal_status_o           <= status_d;
         cal_progress_word_0_o  <= status_d[`DBG_W-1:0];
         cal_progress_word_1_o  <= status_d[2*`DBG_W-1:`DBG_W];
         cal_progress_word_2_o  <= status_d[3*`DBG_W-1:2*`DBG_W];
         calibration_complete_o <= complete_d;
         cal_error_o            <= error_d;
      end
   end
endmodule // lrdimm_buffer_cal_status

// File: inc/cal_status_cfg.svh
// constants for the buffer calibration sequencer and its progress status
// assumes inclusion by bare name from the package and the design modules
`ifndef CAL_STATUS_CFG_SVH
`define CAL_STATUS_CFG_SVH

// delay search range
`define TAP_W            6
`define TAP_MAX          6'h3F

// stage table: 6 buffer stages per rank, two ranks, then gate and check
`define STAGE_W          4
`define STAGE_COUNT      14
`define BUF_PER_RANK     4'h6
`define BUF_STAGES_END   4'hC
`define GATE_STAGE       4'hC
`define SANITY_STAGE     4'hD

// per-rank position of each buffer stage
`define POS_PROBE        4'h0
`define POS_RD_CYCLE     4'h1
`define POS_RD_CENTER    4'h2
`define POS_WR_LEVEL     4'h3
`define POS_WR_CYCLE     4'h4
`define POS_WR_CENTER    4'h5

// status vector and debug words
`define STATUS_W         128
`define STATUS_USED      28
`define DBG_W            9
`define DBG_WORDS        3
`define STATUS_RESET     128'h0
`define DBG_RESET        9'h000

`endif

// File: inc/cal_status_pkg.sv
// types shared by the calibration sequencer and its delay search engine
// assumes the cfg header sits on the include path
package cal_status_pkg;
   `include "cal_status_cfg.svh"

   // command issued toward the data buffer and memory
   typedef enum logic [2:0] {
      CMD_NONE    = 3'h0,
      CMD_PRELOAD = 3'h1,
      CMD_WRITE   = 3'h2,
      CMD_READ    = 3'h3,
      CMD_STROBE  = 3'h4,
      CMD_PROGRAM = 3'h5
   } cmd_t;

   // how a search decides from the returned result bit
   typedef enum logic [2:0] {
      MODE_EDGE01 = 3'h0,
      MODE_EDGE10 = 3'h1,
      MODE_CYCLE  = 3'h2,
      MODE_CENTER = 3'h3,
      MODE_CHECK  = 3'h4
   } search_mode_t;

   // sequencer states, gray along idle-setup-run-done
   typedef enum logic [2:0] {
      SEQ_IDLE  = 3'h0,
      SEQ_SETUP = 3'h1,
      SEQ_RUN   = 3'h3,
      SEQ_DONE  = 3'h2,
      SEQ_FAIL  = 3'h6
   } seq_state_t;

   // search engine states
   typedef enum logic [1:0] {
      ENG_IDLE = 2'h0,
      ENG_REQ  = 2'h1,
      ENG_WAIT = 2'h3
   } eng_state_t;
endpackage

// File: rtl/tap_search.sv
// delay search engine: steps a tap, asks for one probe per tap, and
// decides from the returned result bit; assumes one result per probe
`include "cal_status_cfg.svh"
module tap_search
   import cal_status_pkg::*;
(
   // clock, reset, enable
   input  wire logic                      ref_clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      ce_i,
   // control
   input  wire logic                      start_i,
   input  wire cal_status_pkg::search_mode_t mode_i,
   // result returned from the data buffer
   input  wire logic                      result_valid_i,
   input  wire logic                      result_i,
   // search outputs
   output logic                           probe_o,
   output logic [`TAP_W-1:0]              tap_o,
   output logic                           done_o,
   output logic                           fail_o,
   output logic [`TAP_W-1:0]              final_o
);
   import cal_status_pkg::*;

   eng_state_t           st_q, st_d;
   logic [`TAP_W-1:0]    tap_q, tap_d, left_q, left_d, final_q, final_d;
   logic                 prev_q, prev_d, have_q, have_d, seen_q, seen_d;
   logic                 done_d, fail_d, probe_d;
   logic                 at_max, hit;
   logic [`TAP_W:0]      ctr_sum;
   logic [`TAP_W-1:0]    right_tap;

   // window edges for centering
   assign at_max    = (tap_q == `TAP_MAX);
   assign right_tap = result_i ? tap_q : tap_q - 6'h01;
   assign ctr_sum   = {1'b0, left_q} + {1'b0, right_tap};

   // decision per returned result
   always_comb begin
      unique case (mode_i)
         MODE_EDGE01: hit = have_q && !prev_q && result_i;
         MODE_EDGE10: hit = have_q && prev_q && !result_i;
         MODE_CYCLE,
         MODE_CHECK:  hit = result_i;
         MODE_CENTER: hit = seen_q && (!result_i || at_max);
         default:     hit = 1'b0;
      endcase
   end

   // next state of the search
   always_comb begin
      st_d    = st_q;
      tap_d   = tap_q;
      left_d  = left_q;
      final_d = final_q;
      prev_d  = prev_q;
      have_d  = have_q;
      seen_d  = seen_q;
      done_d  = 1'b0;
      fail_d  = 1'b0;
      probe_d = 1'b0;
      unique case (st_q)
         ENG_IDLE: if (start_i) begin
            tap_d  = '0;
            have_d = 1'b0;
            seen_d = 1'b0;
            st_d   = ENG_REQ;
         end
         ENG_REQ: begin
            probe_d = 1'b1;
            st_d    = ENG_WAIT;
         end
         ENG_WAIT: if (result_valid_i) begin
            prev_d = result_i;
            have_d = 1'b1;
            if (result_i && !seen_q) begin
               seen_d = 1'b1;                  // left edge found
               left_d = tap_q;
            end
            if (hit) begin
               done_d  = 1'b1;
               final_d = (mode_i == MODE_CENTER) ? ctr_sum[`TAP_W:1]
                                                 : tap_q;
               st_d    = ENG_IDLE;
            end else if (at_max || mode_i == MODE_CHECK) begin
               fail_d = 1'b1;
               st_d   = ENG_IDLE;
            end else begin
               tap_d = tap_q + 6'h01;         // keep stepping
               st_d  = ENG_REQ;
            end
         end
         default: st_d = ENG_IDLE;
      endcase
   end

   // engine registers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st_q    <= ENG_IDLE;
         tap_q   <= '0;
         left_q  <= '0;
         final_q <= '0;
         prev_q  <= 1'b0;
         have_q  <= 1'b0;
         seen_q  <= 1'b0;
         done_o  <= 1'b0;
         fail_o  <= 1'b0;
         probe_o <= 1'b0;
      end else if (ce_i) begin
         st_q    <= st_d;
         tap_q   <= tap_d;
         left_q  <= left_d;
         final_q <= final_d;
         prev_q  <= prev_d;
         have_q  <= have_d;
         seen_q  <= seen_d;
         done_o  <= done_d;
         fail_o  <= fail_d;
         probe_o <= probe_d;
      end
   end

   assign tap_o   = tap_q;
   assign final_o = final_q;
endmodule // tap_search

// File: test/cal_status_sva.sv
// checks on the calibration status and command ports
// assumes a bind into the sequencer top, one clock domain
`include "cal_status_cfg.svh"
module cal_status_sva
   import cal_status_pkg::*;
(
   // clock and reset
   input wire logic                  ref_clk_i,
   input wire logic                  rst_n_i,
   // observed outputs
   input wire logic                  cmd_valid_o,
   input wire cal_status_pkg::cmd_t  cmd_o,
   input wire logic [`TAP_W-1:0]     cmd_delay_o,
   input wire logic [`STATUS_W-1:0]  cal_status_o,
   input wire logic [`DBG_W-1:0]     cal_progress_word_0_o,
   input wire logic [`DBG_W-1:0]     cal_progress_word_1_o,
   input wire logic [`DBG_W-1:0]     cal_progress_word_2_o,
   input wire logic                  calibration_complete_o,
   input wire logic                  cal_error_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import cal_status_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [`TAP_W-1:0] strobe_q;
   wire logic [28:0]  used_w = {1'b0, cal_status_o[27:0]};

   // last strobe probe delay, for the stepping check
   always_ff @(posedge ref_clk_i) begin
      if (cmd_valid_o && cmd_o == CMD_STROBE)
         strobe_q <= cmd_delay_o;
   end

   // write probe, then its read at the same delay
   sequence write_s;
      cmd_valid_o && cmd_o == CMD_WRITE;
   endsequence
   sequence read_s;
      cmd_valid_o && cmd_o == CMD_READ && $stable(cmd_delay_o);
   endsequence

   words_map_a: assert property (
      {cal_progress_word_2_o, cal_progress_word_1_o, cal_progress_word_0_o}
      == cal_status_o[26:0]) else $error("debug words differ from status");
   sticky_bits_a: assert property (
      (cal_status_o & $past(cal_status_o)) == $past(cal_status_o))
      else $error("status bit cleared");
   upper_zero_a: assert property (
      cal_status_o[127:28] == '0) else $error("unused status bits set");
   stage_order_a: assert property (
      ((used_w + 29'h1) & used_w) == '0) else $error("status out of order");
   complete_a: assert property (
      calibration_complete_o |->
      cal_status_o[27:0] == 28'hFFFFFFF && !cal_error_o)
      else $error("complete before all stages done");
   write_pair_a: assert property (
      write_s |=> read_s) else $error("write not followed by read");
   program_done_a: assert property (
      cmd_valid_o && cmd_o == CMD_PROGRAM |->
      |((cal_status_o ^ $past(cal_status_o)) & {64{2'b10}}))
      else $error("program without done bit");
   level_step_a: assert property (
      cmd_valid_o && cmd_o == CMD_STROBE && cmd_delay_o != '0 |->
      cmd_delay_o == strobe_q + 1'b1) else $error("leveling skipped a tap");
endmodule // cal_status_sva

bind lrdimm_buffer_cal_status cal_status_sva i_sva (
   .ref_clk_i, .rst_n_i, .cmd_valid_o, .cmd_o, .cmd_delay_o, .cal_status_o,
   .cal_progress_word_0_o, .cal_progress_word_1_o, .cal_progress_word_2_o,
   .calibration_complete_o, .cal_error_o);

// File: test/data_buffer_model.sv
// behavioural data buffer and memory: answers read and strobe probes
// assumes one command pulse per probe and counts program commands
`include "cal_status_cfg.svh"
module data_buffer_model
   import cal_status_pkg::*;
(
   // clock, reset, commands
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  cmd_valid_i,
   input  wire cal_status_pkg::cmd_t  cmd_i,
   input  wire logic [`TAP_W-1:0]     delay_i,
   // behaviour settings
   input  wire logic [`TAP_W-1:0]     edge_i,
   input  wire logic [`TAP_W-1:0]     left_i,
   input  wire logic [`TAP_W-1:0]     right_i,
   input  wire logic                  check_ok_i,
   input  wire logic [3:0]            lat_i,
   // result on the host data bus
   output logic                       result_valid_o,
   output logic                       result_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import cal_status_pkg::*;
   logic [3:0] prog_q;
   logic       pre_q;
   logic       pend_q;
   logic [3:0] wait_q;
   logic       ans_q;
   logic       res_w;
   wire logic  past_w = delay_i >= edge_i;
   wire logic  win_w  = delay_i >= left_i && delay_i <= right_i;

   // result by stage kind, stage known from programs seen
   always_comb begin
      case (prog_q % 4'h6)
         4'h0:      res_w = delay_i < edge_i;   // read probe
         4'h2, 4'h5: res_w = win_w;             // window compare
         default:   res_w = past_w;
      endcase
      if (prog_q == 4'hC)
         res_w = pre_q ? check_ok_i : past_w;
   end

   // answer after a latency; data line wanders between answers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         {prog_q, pre_q, pend_q, wait_q, ans_q} <= '0;
         {result_valid_o, result_o} <= 2'h0;
      end else begin
         if (cmd_valid_i && cmd_i == CMD_PROGRAM)
            prog_q <= prog_q + 4'h1;
         if (cmd_valid_i && cmd_i == CMD_PRELOAD && prog_q == 4'hC)
            pre_q <= 1'b1;
         result_valid_o <= 1'b0;
         result_o <= ~result_o;
         if (cmd_valid_i && (cmd_i == CMD_READ || cmd_i == CMD_STROBE)) begin
            {pend_q, wait_q, ans_q} <= {1'b1, lat_i, res_w};
         end else if (pend_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (pend_q) begin
            {pend_q, result_valid_o, result_o} <= {2'b01, ans_q};
         end
      end
   end
endmodule // data_buffer_model

// File: test/lrdimm_buffer_cal_status_tb.sv
// self-checking bench for the calibration sequencer and status port
// assumes the data buffer model and the bound checker are compiled
`include "cal_status_cfg.svh"
module lrdimm_buffer_cal_status_tb import cal_status_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   import cal_status_pkg::*;
   // stimulus, outputs and model settings
   logic                 clk, rst_n, start, rvalid, rbit, cmd_valid, ok;
   cmd_t                 cmd;
   logic [`TAP_W-1:0]    delay, etap, ltap, rtap;
   logic [`STATUS_W-1:0] status;
   logic [`DBG_W-1:0]    w0, w1, w2;
   logic                 done, err, rank;
   logic [3:0]           lat;
   logic [31:0]          seed;
   logic [27:0]          prev;
   logic [`TAP_W-1:0]    expq[$];
   int                   failures, checked;

   lrdimm_buffer_cal_status i_dut (
      .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .cal_start_i(start),
      .dq_result_valid_i(rvalid), .dq_result_i(rbit),
      .cmd_valid_o(cmd_valid), .cmd_o(cmd), .cmd_rank_o(rank),
      .cmd_delay_o(delay), .cal_status_o(status),
      .cal_progress_word_0_o(w0), .cal_progress_word_1_o(w1),
      .cal_progress_word_2_o(w2), .calibration_complete_o(done),
      .cal_error_o(err));
   data_buffer_model i_buf (
      .ref_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid),
      .cmd_i(cmd), .delay_i(delay), .edge_i(etap), .left_i(ltap),
      .right_i(rtap), .check_ok_i(ok), .lat_i(lat),
      .result_valid_o(rvalid), .result_o(rbit));

   // clock, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic check(input string what, input logic [127:0] exp,
                        input logic [127:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      if (failures == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one calibration run; cut > 0 stops it early for a mid-run reset
   task automatic run(input logic okv, input logic [3:0] lv, input int cut);
      logic [`TAP_W-1:0] e, l, r, c;
      int n;
      rst_n <= 1'b0;
      expq.delete();
      repeat (8) @(posedge clk);
      check("reset status", '0, status);
      seed = lfsr(seed);
      e = 6'(seed[5:0] % 6'h3E) + 6'h01;
      l = 6'(seed[12:8]);
      r = l + 6'(seed[20:16] % 5'h1E) + 6'h01;
      c = 6'((7'(l) + 7'(r)) >> 1);
      repeat (2) expq = {expq, e, e, c, e, e, c};
      {rst_n, start, etap, ltap, rtap, ok, lat} <= {2'b11, e, l, r, okv, lv};
      @(posedge clk);
      start <= 1'b0;
      for (n = 0; n < (cut > 0 ? cut : 20000) && done !== 1'b1
           && err !== 1'b1; n++)
         @(posedge clk);
      if (cut > 0)
         return;
      if (n == 20000) begin
         failures++;
         conclude();
      end
      repeat (3) @(posedge clk);
      check("complete", 128'(okv), 128'(done));
      check("error", 128'(!okv), 128'(err));
      check("status", okv ? 128'hFFFFFFF : 128'h7FFFFFF, status);
      check("words", 128'h7FFFFFF, {w2, w1, w0});
      check("programs left", 128'h0, 128'(expq.size()));
   endtask

   // programmed delays against the oldest note; status grows bit by bit
   always @(posedge clk) begin
      if (rst_n && cmd_valid === 1'b1 && cmd === CMD_PROGRAM) begin
         if (expq.size() == 0)
            check("extra program", 128'h0, 128'h1);
         else begin
            check("rank", 128'(expq.size() <= 6), 128'(rank));
            check("delay", 128'(expq.pop_front()), 128'(delay));
         end
      end
      if (!rst_n)
         prev <= '0;
      else if (status[27:0] !== prev) begin
         check("step", {prev[26:0], 1'b1}, status[27:0]);
         prev <= status[27:0];
      end
   end

   // main sequence: pass, mid-run reset, slow answers with a failed check
   initial begin
      {rst_n, start, ok, lat, prev} = '0;
      {etap, ltap, rtap} = {6'h01, 6'h00, 6'h01};
      {seed, failures, checked} = {32'hA8860B18, 32'h0, 32'h0};
      run(1'b1, 4'h0, 0);
      run(1'b1, 4'h2, 300);
      run(1'b0, 4'h3, 0);
      conclude();
   end
endmodule // lrdimm_buffer_cal_status_tb
